// >>> include/pfci_pkg.sv
// Constants and types for the prefetch and configuration invalidation block
// Notes on behaviour
// R1 - Prefetch addresses base plus n times stride
// R2 - Non-zero stride ignored or illegal; revision option
// R3 - Prefetch is best effort, nothing guaranteed
// R4 - Size gives power-of-two translation count
// R5 - Nonsecure attribute feeds secure stage 2 only
// R6 - Software keeps nonsecure attribute zero when reserved
// R7 - Prefetch walk count is capped
// R8 - Flag updates behave like speculative reads
// R9 - Software invalidates after changing structures
// R10 - Software assumes structures cached independently
// R11 - Invalidation removes at least selected structures
// R12 - Stream entry invalidation leaves TLB alone
// R13 - Secure queue: security select picks state
// R14 - Non-secure queue touches only non-secure entries
// R15 - Leaf zero also drops level-1 stream pointers
// R16 - Single entry drops context descriptors and pointers
// R17 - Stream invalidation drops virtual machine structure data
// R18 - Span is aligned two^(range+1) identifiers
// R19 - Span drops level-1 stream pointers inside
// R20 - Span drops context data within span
// R21 - Range 31 invalidates everything for state
// R22 - Software prefers leaf one form
// R23 - Non-secure queue with security select illegal
// R24 - Disabled unit consumes prefetch without action
// R25 - Commands consumed in order after effects
package pfci_pkg;
    localparam int SID_W       = 32;
    localparam int SIZE_W      = 5;
    localparam int STRIDE_W    = 5;
    localparam int RANGE_W     = 5;
    localparam int ADDR_W      = 64;
    localparam int PAGE_SHIFT  = 12;
    localparam logic [RANGE_W-1:0] RANGE_ALL = 5'h1F;
    // Walk cap keeps one prefetch bounded to at most 64 walks
    localparam logic [15:0] WALK_CAP     = 16'h0040;
    localparam logic [7:0]  OP_PREFETCH  = 8'h02;
    localparam logic [7:0]  OP_INV_ENTRY = 8'h03;
    localparam logic [7:0]  OP_INV_SPAN  = 8'h04;
    localparam logic [7:0]  OP_INV_ALL   = 8'h05;

    typedef enum logic [1:0]
    {
        PFCI_IDLE  = 2'b00,
        PFCI_WALK  = 2'b01,
        PFCI_INVAL = 2'b10,
        PFCI_DONE  = 2'b11
    } pfci_state_t;
endpackage

// >>> rtl/pfci_addr.sv
// Prefetch address generator: base plus index scaled by stride
module pfci_addr
    import pfci_pkg::*;
(
    // Inputs
    input  wire logic [ADDR_W-1:0]   base,
    input  wire logic [STRIDE_W-1:0] stride,
    input  wire logic [15:0]         index,
    // Address
    output logic      [ADDR_W-1:0]   addr
);
    logic [ADDR_W-1:0] offs;

    always_comb
    begin
        offs = {48'h0, index} << ({27'h0, stride} + PAGE_SHIFT); // [R1]
        addr = base + offs;
    end
endmodule

// >>> rtl/pfci_span.sv
// Aligned stream identifier span computation for ranged invalidation
module pfci_span
    import pfci_pkg::*;
(
    // Request
    input  wire logic [SID_W-1:0]   sid,
    input  wire logic [RANGE_W-1:0] range,
    // Span
    output logic      [SID_W-1:0]   first,
    output logic      [SID_W-1:0]   last
);
    logic [SID_W-1:0] mask;

    always_comb
    begin
        // Mask of low range+1 bits; range 31 covers every bit
        mask  = ~({SID_W{1'b1}} << ({27'h0, range} + 32'h1));
        if (range == RANGE_ALL)
        begin
            mask = {SID_W{1'b1}};
        end
        first = sid & ~mask;  // [R18]
        last  = first | mask; // [R18]
    end
endmodule

// >>> rtl/pfci_top.sv
// Command interpreter for address prefetch and configuration invalidation
module pfci_top
    import pfci_pkg::*;
(
    // Clock and reset
    input  wire logic                CLK,
    input  wire logic                NRST,
    // Configuration
    input  wire logic                TRANSLATION_UNIT_ENABLE,
    input  wire logic                SECURE_STAGE2_SUPPORTED,
    input  wire logic                STRIDE_SUPPORTED,
    input  wire logic                STRIDE_STRICT,
    // Command in
    input  wire logic                CMD_VALID,
    output logic                     CMD_READY,
    input  wire logic [7:0]          CMD_OPCODE,
    input  wire logic                CMD_SECURE_QUEUE,
    input  wire logic                CMD_SECURITY_SELECT,
    input  wire logic [SID_W-1:0]    CMD_STREAM_IDENTIFIER,
    input  wire logic                CMD_SUBSTREAM_VALID,
    input  wire logic [19:0]         CMD_SUBSTREAM_IDENTIFIER,
    input  wire logic [ADDR_W-1:0]   CMD_ADDR,
    input  wire logic                CMD_NONSECURE_ATTR,
    input  wire logic [SIZE_W-1:0]   CMD_SIZE,
    input  wire logic [STRIDE_W-1:0] CMD_STRIDE,
    input  wire logic                CMD_LEAF,
    input  wire logic [RANGE_W-1:0]  CMD_RANGE,
    // Translation walk requests
    output logic                     WALK_VALID,
    input  wire logic                WALK_READY,
    output logic [ADDR_W-1:0]        WALK_ADDR,
    output logic [SID_W-1:0]         WALK_STREAM_IDENTIFIER,
    output logic                     WALK_SECURE,
    output logic                     WALK_SUBSTREAM_VALID,
    output logic [19:0]              WALK_SUBSTREAM_IDENTIFIER,
    output logic                     WALK_NONSECURE_ATTR,
    output logic                     WALK_SPECULATIVE,
    // Configuration cache invalidation
    output logic                     INV_VALID,
    input  wire logic                INV_DONE,
    output logic [SID_W-1:0]         INV_FIRST,
    output logic [SID_W-1:0]         INV_LAST,
    output logic                     INV_SECURE,
    output logic                     INV_STREAM_ENTRY,
    output logic                     INV_LEVEL1_STREAM_POINTER,
    output logic                     INV_CONTEXT_DESCRIPTOR,
    output logic                     INV_LEVEL1_CONTEXT_POINTER,
    output logic                     INV_VIRTUAL_MACHINE_STRUCTURE,
    output logic                     INV_ALL,
    // Status
    output logic                     CONSUME,
    output logic                     ILLEGAL_COMMAND_ERROR
);
    pfci_state_t       state_reg, state_next;
    logic [ADDR_W-1:0] base_reg, base_next;
    logic [STRIDE_W-1:0] stride_reg, stride_next;
    logic [15:0]       idx_reg, idx_next;
    logic [15:0]       cnt_reg, cnt_next;
    logic [SID_W-1:0]  sid_reg, sid_next;
    logic              sec_reg, sec_next;
    logic              ssv_reg, ssv_next;
    logic [19:0]       ssid_reg, ssid_next;
    logic              nsa_reg, nsa_next;
    logic              leaf_reg, leaf_next;
    logic              span_reg, span_next;
    logic [RANGE_W-1:0] range_reg, range_next;
    logic              err_reg, err_next;
    logic              cons_reg, cons_next;
    logic [SID_W-1:0]  span_first, span_last;
    logic [ADDR_W-1:0] gen_addr;
    logic              is_pf, is_ent, is_span, is_all, illegal;
    logic [16:0]       want;

    pfci_span u_span
    (
        .sid   (sid_reg),
        .range (range_reg),
        .first (span_first),
        .last  (span_last)
    );

    pfci_addr u_addr
    (
        .base   (base_reg),
        .stride (stride_reg),
        .index  (idx_reg),
        .addr   (gen_addr)
    );

    always_comb
    begin
        is_pf   = CMD_OPCODE == OP_PREFETCH;
        is_ent  = CMD_OPCODE == OP_INV_ENTRY;
        is_span = CMD_OPCODE == OP_INV_SPAN;
        is_all  = CMD_OPCODE == OP_INV_ALL;
        illegal = !(is_pf || is_ent || is_span || is_all);
        if (!CMD_SECURE_QUEUE && CMD_SECURITY_SELECT)
        begin
            illegal = 1'b1; // [R23]
        end
        if (is_pf && !STRIDE_SUPPORTED && STRIDE_STRICT && CMD_STRIDE != 5'h00)
        begin
            illegal = 1'b1; // [R2]
        end
    end

    // Count requested: 2^size, capped by the walk limit
    always_comb
    begin
        want = 17'h00001 << cnt_reg[4:0]; // [R4]
        // Sizes above 16 shift out of the word and would read as zero
        if (cnt_reg[4:0] > 5'h10 || want > {1'b0, WALK_CAP})
        begin
            want = {1'b0, WALK_CAP}; // [R7]
        end
    end

    always_comb
    begin
        state_next  = state_reg;
        base_next   = base_reg;
        stride_next = stride_reg;
        idx_next    = idx_reg;
        cnt_next    = cnt_reg;
        sid_next    = sid_reg;
        sec_next    = sec_reg;
        ssv_next    = ssv_reg;
        ssid_next   = ssid_reg;
        nsa_next    = nsa_reg;
        leaf_next   = leaf_reg;
        span_next   = span_reg;
        range_next  = range_reg;
        err_next    = err_reg;
        cons_next   = 1'b0;
        case (state_reg)
            PFCI_IDLE:
            begin
                // Stops on error; a reset restarts consumption
                if (CMD_VALID && !err_reg)
                begin
                    sid_next   = CMD_STREAM_IDENTIFIER;
                    // Non-secure queue only ever reaches non-secure entries
                    sec_next   = CMD_SECURE_QUEUE & CMD_SECURITY_SELECT; // [R13] [R14]
                    ssv_next   = CMD_SUBSTREAM_VALID;
                    ssid_next  = CMD_SUBSTREAM_IDENTIFIER;
                    // Attribute only reaches secure stage 2 when it may be set
                    nsa_next   = CMD_NONSECURE_ATTR & SECURE_STAGE2_SUPPORTED
                                 & CMD_SECURE_QUEUE & CMD_SECURITY_SELECT; // [R5]
                    leaf_next  = CMD_LEAF;
                    base_next  = {CMD_ADDR[ADDR_W-1:PAGE_SHIFT], 12'h000};
                    stride_next = STRIDE_SUPPORTED ? CMD_STRIDE : 5'h00; // [R2]
                    cnt_next   = {11'h000, CMD_SIZE};
                    idx_next   = 16'h0000;
                    span_next  = is_span | is_all;
                    range_next = is_all ? RANGE_ALL : CMD_RANGE; // [R21]
                    if (illegal)
                    begin
                        err_next = 1'b1;
                    end
                    else if (is_pf)
                    begin
                        // Disabled unit: consumed, nothing fetched
                        state_next = TRANSLATION_UNIT_ENABLE ? PFCI_WALK : PFCI_DONE; // [R24]
                    end
                    else
                    begin
                        state_next = PFCI_INVAL;
                    end
                end
            end
            PFCI_WALK:
            begin
                if (WALK_READY)
                begin
                    idx_next = idx_reg + 16'h0001;
                    if ({1'b0, idx_reg} + 17'h00001 >= want)
                    begin
                        state_next = PFCI_DONE; // [R7]
                    end
                end
            end
            PFCI_INVAL:
            begin
                if (INV_DONE)
                begin
                    state_next = PFCI_DONE; // [R25]
                end
            end
            PFCI_DONE:
            begin
                cons_next  = 1'b1; // [R25]
                state_next = PFCI_IDLE;
            end
            default:
            begin
                state_next = PFCI_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_reg  <= PFCI_IDLE;
            base_reg   <= 64'h0;
            stride_reg <= 5'h00;
            idx_reg    <= 16'h0000;
            cnt_reg    <= 16'h0000;
            sid_reg    <= 32'h0;
            sec_reg    <= 1'b0;
            ssv_reg    <= 1'b0;
            ssid_reg   <= 20'h00000;
            nsa_reg    <= 1'b0;
            leaf_reg   <= 1'b0;
            span_reg   <= 1'b0;
            range_reg  <= 5'h00;
            err_reg    <= 1'b0;
            cons_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            base_reg   <= base_next;
            stride_reg <= stride_next;
            idx_reg    <= idx_next;
            cnt_reg    <= cnt_next;
            sid_reg    <= sid_next;
            sec_reg    <= sec_next;
            ssv_reg    <= ssv_next;
            ssid_reg   <= ssid_next;
            nsa_reg    <= nsa_next;
            leaf_reg   <= leaf_next;
            span_reg   <= span_next;
            range_reg  <= range_next;
            err_reg    <= err_next;
            cons_reg   <= cons_next;
        end
    end

    assign CMD_READY             = (state_reg == PFCI_IDLE) && !err_reg;
    assign CONSUME               = cons_reg;
    assign ILLEGAL_COMMAND_ERROR = err_reg;

    // Best effort walks; the walker may drop any of them
    assign WALK_VALID                = state_reg == PFCI_WALK; // [R3]
    assign WALK_ADDR                 = gen_addr; // [R1]
    assign WALK_STREAM_IDENTIFIER    = sid_reg;
    assign WALK_SECURE               = sec_reg;
    assign WALK_SUBSTREAM_VALID      = ssv_reg;
    assign WALK_SUBSTREAM_IDENTIFIER = ssid_reg;
    assign WALK_NONSECURE_ATTR       = nsa_reg; // [R5]
    assign WALK_SPECULATIVE          = 1'b1; // [R8]

    // Single entry spans one identifier; TLB is never touched here
    assign INV_VALID                     = state_reg == PFCI_INVAL; // [R11] [R12]
    assign INV_FIRST                     = span_reg ? span_first : sid_reg; // [R18]
    assign INV_LAST                      = span_reg ? span_last : sid_reg;
    assign INV_SECURE                    = sec_reg; // [R13]
    assign INV_STREAM_ENTRY              = 1'b1;
    assign INV_LEVEL1_STREAM_POINTER     = span_reg | !leaf_reg; // [R15] [R19]
    assign INV_CONTEXT_DESCRIPTOR        = 1'b1; // [R16] [R20]
    assign INV_LEVEL1_CONTEXT_POINTER    = 1'b1; // [R16] [R20]
    assign INV_VIRTUAL_MACHINE_STRUCTURE = 1'b1; // [R17]
    assign INV_ALL                       = span_reg && range_reg == RANGE_ALL; // [R21]
endmodule

// >>> tb/pfci_cache_model.sv
// Walker and configuration cache responder beside the interpreter
module pfci_cache_model
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic NRST,
    // Pacing and requests
    input  wire logic slow,
    input  wire logic walk_valid,
    input  wire logic inv_valid,
    // Answers
    output logic      walk_ready,
    output logic      inv_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lfsr_reg;
    logic [7:0] lfsr_next;
    logic       gate;
    always_comb
    begin
        lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            lfsr_reg <= 8'h01;
        else
            lfsr_reg <= lfsr_next;
    end
    // Slow mode stalls on a pseudo-random pattern
    assign gate = !slow || lfsr_reg[0];
    // Answers only while a request stands; no TLB is held here
    assign walk_ready = walk_valid && gate;
    assign inv_done = inv_valid && gate;
endmodule

// >>> tb/pfci_properties.sv
// Port-level checks of the command interpreter
module pfci_properties
    import pfci_pkg::*;
(
    // Clock and reset
    input wire logic             CLK,
    input wire logic             NRST,
    // Command and status
    input wire logic             CMD_VALID,
    input wire logic             CMD_READY,
    input wire logic [7:0]       CMD_OPCODE,
    input wire logic             CMD_SECURE_QUEUE,
    input wire logic             CMD_SECURITY_SELECT,
    input wire logic             TRANSLATION_UNIT_ENABLE,
    input wire logic             CONSUME,
    input wire logic             ILLEGAL_COMMAND_ERROR,
    // Walks and invalidation
    input wire logic             WALK_VALID,
    input wire logic             WALK_READY,
    input wire logic             INV_VALID,
    input wire logic             INV_DONE,
    input wire logic [SID_W-1:0] INV_FIRST,
    input wire logic [SID_W-1:0] INV_LAST
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic             take;
    logic [SID_W-1:0] span;
    logic [7:0]       walks_reg;
    logic [7:0]       walks_next;
    assign take = CMD_VALID && CMD_READY;
    assign span = INV_LAST - INV_FIRST;
    always_comb
    begin
        walks_next = walks_reg;
        if (take)
            walks_next = 8'h00;
        else if (WALK_VALID && WALK_READY)
            walks_next = walks_reg + 8'h01;
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            walks_reg <= 8'h00;
        else
            walks_reg <= walks_next;
    end
    busy_after_take_a: assert property (take |=> !CMD_READY)
        else $error("ready high after a take");
    bad_opcode_a: assert property (take && !(CMD_OPCODE inside {[OP_PREFETCH:OP_INV_ALL]}) |=> ILLEGAL_COMMAND_ERROR)
        else $error("reserved opcode not refused");
    ns_select_a: assert property (take && !CMD_SECURE_QUEUE && CMD_SECURITY_SELECT |=> ILLEGAL_COMMAND_ERROR)
        else $error("nonsecure queue select not refused");
    error_sticky_a: assert property (ILLEGAL_COMMAND_ERROR |-> !CMD_READY && !CONSUME ##1 ILLEGAL_COMMAND_ERROR)
        else $error("error state left or consumed");
    idle_prefetch_a: assert property (take && CMD_OPCODE == OP_PREFETCH && !TRANSLATION_UNIT_ENABLE
        |=> ILLEGAL_COMMAND_ERROR or (!WALK_VALID ##1 CONSUME))
        else $error("disabled prefetch walked or lingered");
    cmd_bounded_a: assert property (take |-> ##[1:1000] (CONSUME || ILLEGAL_COMMAND_ERROR))
        else $error("command never finished");
    walk_cap_a: assert property (walks_reg <= 8'h40)
        else $error("too many walks for one prefetch");
    span_aligned_a: assert property (INV_VALID |-> ((span & (span + 32'h1)) == 32'h0) && ((INV_FIRST & span) == 32'h0))
        else $error("span not aligned power of two");
    inv_hold_a: assert property (INV_VALID && !INV_DONE |=> INV_VALID && $stable(INV_FIRST) && $stable(INV_LAST))
        else $error("invalidation request dropped");
    inv_finish_a: assert property (INV_VALID && INV_DONE |=> !INV_VALID ##1 CONSUME)
        else $error("no consume after invalidation");
    consume_pulse_a: assert property (CONSUME |=> !CONSUME)
        else $error("consume longer than a cycle");
    cover property (take && CMD_OPCODE == OP_PREFETCH ##[1:300] CONSUME);
    cover property (INV_VALID && INV_DONE);
    cover property ($rose(ILLEGAL_COMMAND_ERROR));
endmodule

// >>> tb/pfci_top_tb.sv
// Self-checking bench for the prefetch and invalidation interpreter
module pfci_top_tb
    import pfci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              CLK = 1'b0, NRST = 1'b0, slow = 1'b0;
    logic              TRANSLATION_UNIT_ENABLE = 1'b1, SECURE_STAGE2_SUPPORTED = 1'b1;
    logic              STRIDE_SUPPORTED = 1'b1, STRIDE_STRICT = 1'b0, CMD_VALID = 1'b0;
    logic              CMD_SECURE_QUEUE = 1'b0, CMD_SECURITY_SELECT = 1'b0, CMD_SUBSTREAM_VALID = 1'b0;
    logic              CMD_NONSECURE_ATTR = 1'b0, CMD_LEAF = 1'b0;
    logic [7:0]        CMD_OPCODE = 8'h00;
    logic [SID_W-1:0]  CMD_STREAM_IDENTIFIER = '0, WALK_STREAM_IDENTIFIER, INV_FIRST, INV_LAST;
    logic [19:0]       CMD_SUBSTREAM_IDENTIFIER = '0, WALK_SUBSTREAM_IDENTIFIER;
    logic [ADDR_W-1:0] CMD_ADDR = '0, WALK_ADDR;
    logic [4:0]        CMD_SIZE = '0, CMD_STRIDE = '0, CMD_RANGE = '0;
    logic              CMD_READY, WALK_VALID, WALK_READY, WALK_SECURE, WALK_SUBSTREAM_VALID;
    logic              WALK_NONSECURE_ATTR, WALK_SPECULATIVE, INV_VALID, INV_DONE, INV_SECURE, INV_ALL;
    logic              INV_STREAM_ENTRY, INV_LEVEL1_STREAM_POINTER, INV_CONTEXT_DESCRIPTOR;
    logic              INV_LEVEL1_CONTEXT_POINTER, INV_VIRTUAL_MACHINE_STRUCTURE, CONSUME, ILLEGAL_COMMAND_ERROR;
    int                num_errors = 0, n_checks = 0;
    logic [31:0]       seed = 32'h15;

    pfci_top DUT (.*);
    pfci_cache_model u_cache (.CLK(CLK), .NRST(NRST), .slow(slow), .walk_valid(WALK_VALID),
        .inv_valid(INV_VALID), .walk_ready(WALK_READY), .inv_done(INV_DONE));

    always #20 CLK = ~CLK;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [63:0] walk_addr(input logic [15:0] n);
        logic [4:0] st;
        st = STRIDE_SUPPORTED ? CMD_STRIDE : 5'h00;
        return {CMD_ADDR[63:12], 12'h000} + ({48'h0, n} << (12 + st));
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset();
        NRST <= 1'b0;
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
    endtask

    // Fields go out with valid; outputs are read at the falling edge, where they have settled
    task automatic run_cmd();
        logic        bad, sec, inv_seen;
        logic [15:0] n, want;
        logic [32:0] sz;
        logic [31:0] first;
        CMD_VALID <= 1'b1;
        @(negedge CLK);
        for (int i = 0; i < 50 && !CMD_READY; i++)
            @(negedge CLK);
        check(CMD_READY, 1'b1, "ready before take");
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        bad = !(CMD_OPCODE inside {[OP_PREFETCH:OP_INV_ALL]}) || (!CMD_SECURE_QUEUE && CMD_SECURITY_SELECT)
            || (CMD_OPCODE == OP_PREFETCH && !STRIDE_SUPPORTED && STRIDE_STRICT && CMD_STRIDE != 5'h00);
        sec = CMD_SECURE_QUEUE & CMD_SECURITY_SELECT;
        want = (CMD_OPCODE == OP_PREFETCH && TRANSLATION_UNIT_ENABLE && !bad)
            ? ((CMD_SIZE > 5'h06) ? 16'h0040 : (16'h0001 << CMD_SIZE)) : 16'h0000;
        sz = (CMD_OPCODE == OP_INV_ALL) ? 33'h100000000 : (CMD_OPCODE == OP_INV_ENTRY) ? 33'h1 : (33'h1 << (CMD_RANGE + 1));
        first = CMD_STREAM_IDENTIFIER & ~(sz[31:0] - 32'h1);
        n = 16'h0000;
        inv_seen = 1'b0;
        for (int i = 0; i < 2000; i++)
        begin
            @(negedge CLK);
            if (WALK_VALID && WALK_READY)
            begin
                check(WALK_ADDR, walk_addr(n), "walk address");
                check({WALK_NONSECURE_ATTR, WALK_SECURE, WALK_SPECULATIVE},
                    {CMD_NONSECURE_ATTR & sec & SECURE_STAGE2_SUPPORTED, sec, 1'b1}, "walk attributes");
                n++;
            end
            if (INV_VALID && INV_DONE)
            begin
                inv_seen = 1'b1;
                check({INV_FIRST, INV_LAST}, {first, first + sz[31:0] - 32'h1}, "span");
                check({INV_SECURE, INV_ALL, INV_LEVEL1_STREAM_POINTER}, {sec, sz[32],
                    CMD_OPCODE != OP_INV_ENTRY || !CMD_LEAF}, "scope");
                check({INV_STREAM_ENTRY, INV_CONTEXT_DESCRIPTOR, INV_LEVEL1_CONTEXT_POINTER,
                    INV_VIRTUAL_MACHINE_STRUCTURE}, 64'hF, "kinds");
            end
            if (CONSUME || ILLEGAL_COMMAND_ERROR)
                break;
        end
        check({ILLEGAL_COMMAND_ERROR, CONSUME}, {bad, !bad}, "outcome");
        check(n, want, "walk count");
        check(inv_seen, !bad && CMD_OPCODE != OP_PREFETCH, "invalidation seen");
        @(posedge CLK);
    endtask

    task automatic set_cmd(input logic [7:0] op, input logic [4:0] size, input logic [4:0] stride,
        input logic [4:0] rng, input logic ns_sel);
        logic [31:0] r;
        r = xs();
        CMD_OPCODE <= op;
        CMD_SECURE_QUEUE <= r[0] & !ns_sel;
        CMD_SECURITY_SELECT <= (r[0] & r[1]) | ns_sel;
        CMD_NONSECURE_ATTR <= r[0] & r[1] & r[2] & SECURE_STAGE2_SUPPORTED;
        CMD_LEAF <= r[3];
        CMD_SUBSTREAM_VALID <= r[4];
        CMD_SUBSTREAM_IDENTIFIER <= r[24:5];
        CMD_STREAM_IDENTIFIER <= xs();
        CMD_ADDR <= {xs(), xs()};
        CMD_SIZE <= size;
        CMD_STRIDE <= stride;
        CMD_RANGE <= rng;
        run_cmd();
    endtask

    initial
    begin
        logic [31:0] r;
        do_reset();
        set_cmd(OP_PREFETCH, 5'h00, 5'h00, 5'h00, 1'b0);
        set_cmd(OP_PREFETCH, 5'h06, 5'h03, 5'h00, 1'b0);
        set_cmd(OP_PREFETCH, 5'h1F, 5'h1F, 5'h00, 1'b0);
        slow <= 1'b1;
        STRIDE_SUPPORTED <= 1'b0;
        set_cmd(OP_PREFETCH, 5'h02, 5'h05, 5'h00, 1'b0);
        TRANSLATION_UNIT_ENABLE <= 1'b0;
        set_cmd(OP_PREFETCH, 5'h03, 5'h00, 5'h00, 1'b0);
        set_cmd(OP_INV_SPAN, 5'h00, 5'h00, 5'h1F, 1'b0);
        set_cmd(OP_INV_SPAN, 5'h00, 5'h00, 5'h00, 1'b0);
        set_cmd(OP_INV_ALL, 5'h00, 5'h00, 5'h07, 1'b0);
        $display("corner tests done");
        for (int k = 0; k < 40; k++)
        begin
            r = xs();
            {TRANSLATION_UNIT_ENABLE, STRIDE_SUPPORTED, SECURE_STAGE2_SUPPORTED, slow} <= r[3:0];
            set_cmd(OP_PREFETCH + {6'h00, r[5:4]}, {2'b00, r[8:6]} % 5'h06, r[13:9], r[18:14], 1'b0);
        end
        $display("random tests done");
        STRIDE_STRICT <= 1'b1;
        STRIDE_SUPPORTED <= 1'b0;
        set_cmd(OP_PREFETCH, 5'h01, 5'h02, 5'h00, 1'b0);
        do_reset();
        set_cmd(OP_INV_ENTRY, 5'h00, 5'h00, 5'h00, 1'b1);
        do_reset();
        set_cmd(8'h06, 5'h00, 5'h00, 5'h00, 1'b0);
        $display("refusal tests done");
        report_and_stop();
    end

    initial
    begin
        #2000000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule

bind pfci_top pfci_properties u_props (.*);
